// file: hdl/fsq_core.sv
// word program sequencer with status, query and interrupt logic
`timescale 1ns/1ps
module fsq_core #(
  parameter bit LARGE_DENSITY = 1'b0
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [fsq_pkg::ADDR_W-1:0] addr,
  input wire logic [fsq_pkg::DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [fsq_pkg::DATA_W-1:0] rdata,
  input wire logic vpp_ok,
  input wire logic [fsq_pkg::BLOCKS-1:0] block_lock,
  output logic irq
);
  import fsq_pkg::*;

  //----------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------
  fsq_state_t state; // sequencer state
  fsq_mode_t mode; // read mode
  logic [DATA_W-1:0] mem [WORDS]; // array storage, erased to ones
  logic [WIDX_W-1:0] tgt_idx; // word being programmed
  logic [DATA_W-1:0] tgt_data; // data being programmed
  logic supply_error_flag; // sticky supply error
  logic program_error_flag; // sticky program error
  logic block_locked_flag; // sticky lock error
  logic [INT_W-1:0] int_stat; // sticky interrupt events
  logic [INT_W-1:0] int_mask; // interrupt enables
  logic tmr_done; // program time elapsed

  //----------------------------------------------------------------------
  // decode
  //----------------------------------------------------------------------
  wire wr_take = wr & clk_en;
  wire rd_take = rd & clk_en;
  // interrupt registers sit outside the command space
  wire is_stat_reg = (addr == OFS_INT_STAT);
  wire is_mask_reg = (addr == OFS_INT_MASK);
  wire is_reg = is_stat_reg | is_mask_reg;
  wire cmd_wr = wr_take & ~is_reg; // flash bus write
  wire [7:0] cmd = wdata[7:0];
  wire in_array = (addr < ADDR_W'(WORDS));
  wire [WIDX_W-1:0] widx = addr[WIDX_W-1:0];
  // lock input of the block that holds the addressed word
  wire [1:0] blk = addr[BLK_HI:BLK_LO];

  // setup code seen while idle
  wire do_setup = cmd_wr & (state == st_idle) & (cmd == CMD_SETUP);
  // second write after setup
  wire data_wr = cmd_wr & (state == st_armed);
  // supply bad now or still flagged
  wire refuse_supply = data_wr & (supply_error_flag | ~vpp_ok);
  wire refuse_lock = data_wr & ~refuse_supply & block_lock[blk];
  wire launch = data_wr & ~refuse_supply & ~refuse_lock;
  wire do_clear = cmd_wr & (state == st_idle) & (cmd == CMD_CLEAR);

  // stored value: bits can only go from one to zero
  wire [DATA_W-1:0] stored = mem[tgt_idx] & tgt_data;
  wire store_fail = tmr_done & (stored != tgt_data);

  // status byte
  wire [7:0] status_byte = {(state != st_busy), 2'b00, program_error_flag,
                            supply_error_flag, 1'b0, block_locked_flag,
                            1'b0};

  // events raised this cycle
  wire [INT_W-1:0] events = {refuse_lock, store_fail, refuse_supply,
                             tmr_done};

  //----------------------------------------------------------------------
  // program timer
  //----------------------------------------------------------------------
  // frozen with the rest of the block while clk_en is low
  fsq_timer #(
    .CYCLES(PROG_CYC)
  ) u_timer (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .start(launch),
    .done(tmr_done)
  );

  //----------------------------------------------------------------------
  // sequencer state
  //----------------------------------------------------------------------
  fsq_state_t next_state;

  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        if (do_setup) begin
          next_state = st_armed;
        end
      end
      st_armed: begin
        if (launch) begin
          next_state = st_busy;
        end else if (data_wr) begin
          next_state = st_idle;
        end
      end
      st_busy: begin
        if (tmr_done) begin
          next_state = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= st_idle;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  //----------------------------------------------------------------------
  // read mode selection
  //----------------------------------------------------------------------
  fsq_mode_t next_mode;
  wire mode_cmd_ok = cmd_wr & (state != st_armed);

  always_comb begin
    next_mode = mode;
    if (do_setup || data_wr) begin
      next_mode = rm_status;
    end else if (mode_cmd_ok && cmd == CMD_READ_ARRAY) begin
      next_mode = rm_array;
    end else if (mode_cmd_ok && cmd == CMD_READ_STATUS) begin
      next_mode = rm_status;
    end else if (mode_cmd_ok && cmd == CMD_QUERY) begin
      next_mode = rm_query;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mode <= rm_array;
    end else if (clk_en) begin
      mode <= next_mode;
    end
  end

  //----------------------------------------------------------------------
  // program target capture
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      tgt_idx <= '0;
      tgt_data <= '0;
    end else if (launch) begin
      tgt_idx <= widx;
      tgt_data <= wdata;
    end
  end

  //----------------------------------------------------------------------
  // array storage
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '1;
      end
    end else if (clk_en && tmr_done) begin
      mem[tgt_idx] <= stored;
    end
  end

  //----------------------------------------------------------------------
  // error flags: set wins over clear
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      supply_error_flag <= 1'b0;
      program_error_flag <= 1'b0;
      block_locked_flag <= 1'b0;
    end else if (clk_en) begin
      supply_error_flag <= refuse_supply |
                           (supply_error_flag & ~do_clear);
      program_error_flag <= store_fail |
                            (program_error_flag & ~do_clear);
      block_locked_flag <= refuse_lock |
                           (block_locked_flag & ~do_clear);
    end
  end

  //----------------------------------------------------------------------
  // interrupt status and mask
  //----------------------------------------------------------------------
  wire stat_rd = rd_take & is_stat_reg;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      int_stat <= '0;
      int_mask <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      int_stat <= events | (int_stat & ~{INT_W{stat_rd}});
      if (wr_take && is_mask_reg) begin
        int_mask <= wdata[INT_W-1:0];
      end
      irq <= |((events | (int_stat & ~{INT_W{stat_rd}})) &
               ((wr_take && is_mask_reg) ? wdata[INT_W-1:0] : int_mask));
    end
  end

  //----------------------------------------------------------------------
  // query table
  //----------------------------------------------------------------------
  logic [7:0] query_byte;
  wire [7:0] cnt_lo = LARGE_DENSITY ? QV_CNT_LARGE : QV_CNT_MID;
  wire [ADDR_W-1:0] reg_ofs = addr - Q_REG_B0;

  always_comb begin
    query_byte = 8'h00;
    if (addr == Q_BLK_CNT_LO) begin
      query_byte = cnt_lo;
    end else if (addr == Q_BLK_CNT_HI) begin
      query_byte = QV_CNT_HI;
    end else if (addr == Q_BLK_SZ_LO) begin
      query_byte = QV_SZ_LO;
    end else if (addr == Q_BLK_SZ_HI) begin
      query_byte = QV_SZ_HI;
    end else if (addr == Q_CAPS) begin
      query_byte = QV_CAPS;
    end else if (addr >= Q_REG_B0 && addr <= Q_REG_B5) begin
      // exponent, legacy bit 15, valid/invalid sizes, legacy bit 47
      query_byte = QV_REGION[{reg_ofs[2:0], 3'b000} +: 8];
    end
  end

  //----------------------------------------------------------------------
  // read data path, valid the cycle after the strobe
  //----------------------------------------------------------------------
  logic [DATA_W-1:0] next_rdata;

  always_comb begin
    next_rdata = '0;
    if (is_stat_reg) begin
      next_rdata = DATA_W'(int_stat);
    end else if (is_mask_reg) begin
      next_rdata = DATA_W'(int_mask);
    end else begin
      case (mode)
        rm_status: next_rdata = DATA_W'(status_byte);
        rm_query: next_rdata = DATA_W'(query_byte);
        rm_array: next_rdata = in_array ? mem[widx] : '0;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rdata <= '0;
    end else if (rd_take) begin
      rdata <= next_rdata;
    end
  end

  //----------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  chk_setup_arms: assert property (
    do_setup |=> state == st_armed)
    else $error("setup code did not arm");

  chk_launch_busy: assert property (
    launch |=> state == st_busy && mode == rm_status && tgt_data ==
      $past(wdata))
    else $error("data write did not launch program");

  chk_busy_ready: assert property (
    rd_take && !is_reg && mode == rm_status |=>
      rdata[SB_READY] == ($past(state) != st_busy))
    else $error("ready bit wrong");

  chk_array_mode: assert property (
    mode_cmd_ok && cmd == CMD_READ_ARRAY && !do_setup |=> mode == rm_array)
    else $error("read array not restored");

  chk_supply_refuse: assert property (
    data_wr && supply_error_flag |=> state == st_idle && supply_error_flag)
    else $error("program ran with supply error");

  chk_store_fail: assert property (
    clk_en && tmr_done && (mem[tgt_idx] & tgt_data) != tgt_data |=>
      program_error_flag)
    else $error("failed store not flagged");

  chk_lock_abort: assert property (
    refuse_lock |=> block_locked_flag && state == st_idle &&
      mem[$past(widx)] == $past(mem[widx]))
    else $error("locked block not aborted");

  chk_err_sticky: assert property (
    program_error_flag && !do_clear |=> program_error_flag)
    else $error("error flag lost without clear");

  chk_status_mode_holds: assert property (
    mode == rm_status && !(mode_cmd_ok && cmd != CMD_READ_STATUS) |=>
      mode == rm_status)
    else $error("status mode left without command");

  chk_query_count: assert property (
    rd_take && mode == rm_query && addr == Q_BLK_CNT_LO |=>
      rdata[7:0] == (LARGE_DENSITY ? QV_CNT_LARGE : QV_CNT_MID))
    else $error("block count byte wrong");

  // a bad supply at the data write refuses the program at once
  chk_supply_bad: assert property (
    data_wr && !vpp_ok |=> state == st_idle && supply_error_flag)
    else $error("program ran with bad supply");

  // supply and lock flags only drop on the clear command
  chk_supply_sticky: assert property (
    supply_error_flag && !do_clear |=> supply_error_flag)
    else $error("supply flag lost without clear");

  chk_lock_sticky: assert property (
    block_locked_flag && !do_clear |=> block_locked_flag)
    else $error("lock flag lost without clear");

  // a low clock enable holds sequencer, mode and outputs
  chk_freeze_hold: assert property (
    !clk_en |=> $stable(state) && $stable(mode) && $stable(rdata) &&
      $stable(irq))
    else $error("state moved while clock enable low");

  // main scenarios reached

  cov_program_ok: cover property (launch ##[1:60] tmr_done && !store_fail);
  cov_program_fail: cover property (store_fail);
  cov_lock_abort: cover property (refuse_lock);
  cov_irq: cover property (irq);
  cov_supply_refuse: cover property (refuse_supply);

endmodule : fsq_core

// file: hdl/fsq_timer.sv
// down counter that times the internal program operation
`timescale 1ns/1ps
module fsq_timer #(
  parameter int CYCLES = 50
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic start,
  output logic done
);
  import fsq_pkg::*;

  // remaining cycles; zero means idle
  logic [TMR_W-1:0] count;

  //----------------------------------------------------------------------
  // count down after start, pulse done on last cycle
  //----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
      done <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start) begin
        count <= TMR_W'(CYCLES);
      end else if (count != '0) begin
        count <= count - 1'b1;
        done <= (count == TMR_W'(1));
      end
    end
  end

endmodule : fsq_timer

// file: inc/fsq_pkg.sv
// constants, command codes and query table of the word program sequencer
//------------------------------------------------------------------------
//------------------------------------------------------------------------
package fsq_pkg;

  // bus and array shape
  localparam int ADDR_W = 9;
  localparam int DATA_W = 16;
  localparam int WORDS = 16;
  localparam int WIDX_W = 4;
  localparam int BLOCKS = 4;
  localparam int BLK_LO = 2;
  localparam int BLK_HI = 3;

  // command codes on the data bus
  localparam logic [7:0] CMD_SETUP = 8'h41;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR = 8'h50;
  localparam logic [7:0] CMD_QUERY = 8'h98;

  // status register bit positions
  localparam int SB_READY = 7;
  localparam int SB_PROG = 4;
  localparam int SB_SUPPLY = 3;
  localparam int SB_LOCK = 1;

  // interrupt register offsets and event bits
  localparam logic [ADDR_W-1:0] OFS_INT_STAT = 9'h1F0;
  localparam logic [ADDR_W-1:0] OFS_INT_MASK = 9'h1F1;
  localparam int INT_W = 4;
  localparam int EV_DONE = 0;
  localparam int EV_SUPPLY = 1;
  localparam int EV_PROG = 2;
  localparam int EV_LOCK = 3;

  // program time
  localparam int CLK_PERIOD_NS = 40;
  localparam int PROG_TIME_NS = 2000;
  localparam int PROG_CYC = (PROG_TIME_NS + CLK_PERIOD_NS - 1)
                            / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

  // query offsets
  localparam logic [ADDR_W-1:0] Q_BLK_CNT_LO = 9'h135;
  localparam logic [ADDR_W-1:0] Q_BLK_CNT_HI = 9'h136;
  localparam logic [ADDR_W-1:0] Q_BLK_SZ_LO = 9'h137;
  localparam logic [ADDR_W-1:0] Q_BLK_SZ_HI = 9'h138;
  localparam logic [ADDR_W-1:0] Q_CAPS = 9'h13C;
  localparam logic [ADDR_W-1:0] Q_REG_B0 = 9'h13D;
  localparam logic [ADDR_W-1:0] Q_REG_B5 = 9'h142;

  // query values
  localparam logic [7:0] QV_CNT_MID = 8'h1F;
  localparam logic [7:0] QV_CNT_LARGE = 8'h3F;
  localparam logic [7:0] QV_CNT_HI = 8'h00;
  localparam logic [7:0] QV_SZ_LO = 8'h00;
  localparam logic [7:0] QV_SZ_HI = 8'h04;
  localparam logic [7:0] QV_CAPS = 8'h03;
  localparam logic [47:0] QV_REGION = 48'h0010_0010_000A;

  // sequencer states and read modes
  typedef enum logic [1:0] {st_idle, st_armed, st_busy} fsq_state_t;
  typedef enum logic [1:0] {rm_array, rm_status, rm_query} fsq_mode_t;

endpackage : fsq_pkg

// file: tb/fsq_host.sv
// host controller model that drives the flash bus of the sequencer
`timescale 1ns/1ps
module fsq_host (
  input wire logic core_clk,
  output logic [fsq_pkg::ADDR_W-1:0] addr,
  output logic [fsq_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [fsq_pkg::DATA_W-1:0] rdata
);
  import fsq_pkg::*;

  //----------------------------------------------------------------------
  // bus idle at time zero
  //----------------------------------------------------------------------
  initial begin
    addr = '0;
    wdata = 16'h5A5A;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one write cycle; data line shows junk once released
  task automatic bus_wr(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : bus_wr

  // one read cycle; data taken in the cycle after the strobe
  task automatic bus_rd(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : bus_rd

  // command code in the low byte
  task automatic cmd(input logic [ADDR_W-1:0] a, input logic [7:0] c);
    bus_wr(a, {8'h00, c});
  endtask : cmd

  // setup code then the data word at the same location
  task automatic prog(input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d);
    bus_wr(a, {8'h00, CMD_SETUP});
    bus_wr(a, d);
  endtask : prog

  // poll status until the ready bit shows, bounded
  task automatic poll(input logic [ADDR_W-1:0] a,
                      output logic [DATA_W-1:0] st);
    int n;
    n = 0;
    st = '0;
    while (st[SB_READY] !== 1'b1 && n < 100) begin
      bus_rd(a, st);
      n++;
    end
  endtask : poll
endmodule : fsq_host

// file: tb/tb.sv
// self-checking testbench of the word program sequencer
`timescale 1ns/1ps
module tb;
  import fsq_pkg::*;

  logic core_clk; // bench clock
  logic reset; // async reset
  logic clk_en; // run enable, high until the final freeze check
  logic vpp_ok; // supply good
  logic [BLOCKS-1:0] block_lock; // per-block lock
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic wr;
  logic rd;
  logic [DATA_W-1:0] rdata; // mid density part
  logic [DATA_W-1:0] rdata_l; // large density part
  logic irq;
  int n_fail;
  int n_checks;
  logic [DATA_W-1:0] v;
  logic [7:0] q_exp [11] = '{8'h1F, 8'h00, 8'h00, 8'h04, 8'h03, 8'h0A,
                             8'h00, 8'h10, 8'h00, 8'h10, 8'h00};

  //----------------------------------------------------------------------
  // instances
  //----------------------------------------------------------------------
  fsq_host host_u (.core_clk(core_clk), .addr(addr), .wdata(wdata),
                   .wr(wr), .rd(rd), .rdata(rdata));
  fsq_core dut_u (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
                  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
                  .rdata(rdata), .vpp_ok(vpp_ok),
                  .block_lock(block_lock), .irq(irq));
  fsq_core #(.LARGE_DENSITY(1'b1)) dut_l (.core_clk(core_clk),
                  .reset(reset), .clk_en(clk_en), .addr(addr),
                  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata_l),
                  .vpp_ok(vpp_ok), .block_lock(block_lock), .irq());

  // 40 ns clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // compare and count
  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask : chk

  // verdict and end of run
  task automatic results();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  // irq sampled one cycle on
  task automatic chk_irq(input logic e);
    @(posedge core_clk);
    #1;
    chk({15'h0000, irq}, {15'h0000, e});
  endtask : chk_irq

  // hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    results();
  end

  //----------------------------------------------------------------------
  // main sequence
  //----------------------------------------------------------------------
  initial begin
    n_fail = 0;
    n_checks = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    vpp_ok = 1'b1;
    block_lock = '0;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    // erased array, unmapped place
    host_u.bus_rd(9'h003, v);
    chk(v, 16'hFFFF);
    host_u.bus_rd(9'h100, v);
    chk(v, 16'h0000);
    // query bytes of block map and programming region
    host_u.cmd(9'h000, CMD_QUERY);
    for (int i = 0; i < 11; i++) begin
      host_u.bus_rd((i < 4) ? 9'h135 + 9'(i) : 9'h138 + 9'(i), v);
      chk(v, {8'h00, q_exp[i]});
      if (i == 0) chk(rdata_l, 16'h003F);
    end
    // good program with interrupt enabled
    host_u.bus_wr(OFS_INT_MASK, 16'h000F);
    host_u.bus_rd(OFS_INT_MASK, v);
    chk(v, 16'h000F);
    host_u.prog(9'h005, 16'h1234);
    host_u.bus_rd(9'h005, v);
    chk(v & 16'h0080, 16'h0000);
    host_u.poll(9'h005, v);
    chk(v, 16'h0080);
    host_u.bus_rd(9'h005, v);
    chk(v, 16'h0080);
    chk_irq(1'b1);
    host_u.bus_rd(OFS_INT_STAT, v);
    chk(v, 16'h0001);
    chk_irq(1'b0);
    host_u.cmd(9'h005, CMD_READ_ARRAY);
    host_u.bus_rd(9'h005, v);
    chk(v, 16'h1234);
    // failed store, then a good word; flag stays over the series
    host_u.prog(9'h005, 16'h00FF);
    host_u.poll(9'h005, v);
    host_u.prog(9'h007, 16'h1111);
    host_u.poll(9'h007, v);
    chk(v, 16'h0090);
    host_u.cmd(9'h005, CMD_READ_ARRAY);
    host_u.bus_rd(9'h005, v);
    chk(v, 16'h0034);
    host_u.bus_rd(9'h007, v);
    chk(v, 16'h1111);
    host_u.cmd(9'h005, CMD_READ_STATUS);
    host_u.bus_rd(9'h005, v);
    chk(v, 16'h0090);
    host_u.cmd(9'h005, CMD_CLEAR);
    host_u.cmd(9'h005, CMD_READ_STATUS);
    host_u.bus_rd(9'h005, v);
    chk(v, 16'h0080);
    // locked block with its interrupt masked
    host_u.bus_wr(OFS_INT_MASK, 16'h0000);
    chk_irq(1'b0);
    block_lock <= 4'b0010;
    host_u.prog(9'h006, 16'h0000);
    host_u.poll(9'h006, v);
    chk(v, 16'h0082);
    chk_irq(1'b0);
    host_u.bus_rd(OFS_INT_STAT, v);
    chk(v & 16'h0008, 16'h0008);
    host_u.cmd(9'h006, CMD_READ_ARRAY);
    host_u.bus_rd(9'h006, v);
    chk(v, 16'hFFFF);
    host_u.cmd(9'h006, CMD_CLEAR);
    block_lock <= 4'b0000;
    // bad supply refuses until cleared
    vpp_ok <= 1'b0;
    host_u.prog(9'h000, 16'h00AA);
    host_u.poll(9'h000, v);
    chk(v, 16'h0088);
    vpp_ok <= 1'b1;
    host_u.prog(9'h000, 16'h00AA);
    host_u.poll(9'h000, v);
    chk(v, 16'h0088);
    host_u.cmd(9'h000, CMD_READ_ARRAY);
    host_u.bus_rd(9'h000, v);
    chk(v, 16'hFFFF);
    host_u.cmd(9'h000, CMD_CLEAR);
    host_u.prog(9'h000, 16'h00AA);
    host_u.poll(9'h000, v);
    chk(v, 16'h0080);
    host_u.cmd(9'h000, CMD_READ_ARRAY);
    host_u.bus_rd(9'h000, v);
    chk(v, 16'h00AA);
    // frozen clock enable: read strobe ignored, old data held
    clk_en <= 1'b0;
    host_u.bus_rd(9'h003, v);
    chk(v, 16'h00AA);
    clk_en <= 1'b1;
    results();
  end
endmodule : tb
